/* File: pkg/arcs_pkg.sv */
// constants shared by both ends of the converter readout link
package arcs_pkg;

  // ----------------------------------------------------------------
  // clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 40;
  localparam int CLK_NS   = 25;
  localparam int DATA_W   = 24;
  localparam int SAMPLE_W = 26;
  localparam int TMR_W    = 25;
  localparam int PCNT_W   = 5;

  // ----------------------------------------------------------------
  // serial clock pulse counts after a ready indication
  // ----------------------------------------------------------------
  localparam logic [4:0] PCNT_DATA  = 5'h18;
  localparam logic [4:0] PCNT_CAL   = 5'h1a;
  localparam logic [4:0] PCNT_SAT   = 5'h1f;
  localparam logic [4:0] PCNT_RESET = 5'h1f;

  // ----------------------------------------------------------------
  // times in microseconds, nominal converter clock
  // ----------------------------------------------------------------
  localparam int T_UPD_US        = 39;
  localparam int T_CONV_FAST_US  = 12500;
  localparam int T_CONV_SLOW_US  = 100000;
  localparam int T_CAL_FAST_US   = 101280;
  localparam int T_CAL_SLOW_US   = 801020;
  localparam int T_STBY_FAST_US  = 12460;
  localparam int T_STBY_SLOW_US  = 99960;
  localparam int T_WAKE_FAST_US  = 52510;
  localparam int T_WAKE_SLOW_US  = 401800;

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam int UPD_CYC       = T_UPD_US * CLK_MHZ;
  localparam int CONV_FAST_CYC = T_CONV_FAST_US * CLK_MHZ;
  localparam int CONV_SLOW_CYC = T_CONV_SLOW_US * CLK_MHZ;
  localparam int CAL_FAST_CYC  = T_CAL_FAST_US * CLK_MHZ;
  localparam int CAL_SLOW_CYC  = T_CAL_SLOW_US * CLK_MHZ;
  localparam int STBY_FAST_CYC = T_STBY_FAST_US * CLK_MHZ;
  localparam int STBY_SLOW_CYC = T_STBY_SLOW_US * CLK_MHZ;
  localparam int WAKE_FAST_CYC = T_WAKE_FAST_US * CLK_MHZ;
  localparam int WAKE_SLOW_CYC = T_WAKE_SLOW_US * CLK_MHZ;

  // host serial clock half period
  localparam int T_SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC  = T_SCLK_HALF_NS / CLK_NS;
  localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_RUN  = 2'h0,
    DEV_STBY = 2'h1,
    DEV_WAKE = 2'h3,
    DEV_CAL  = 2'h2
  } arcs_dev_state_type;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'h0,
    HOST_HIGH = 2'h1,
    HOST_LOW  = 2'h3,
    HOST_STBY = 2'h2
  } arcs_host_state_type;

endpackage

/* File: pkg/arcs_link_if.sv */
// two-wire link between converter and host
`timescale 1ns/1ps
interface arcs_link_if;
  logic sclk;
  logic ready_data_out;

  modport dev  (input sclk, output ready_data_out);
  modport host (output sclk, input ready_data_out);
endinterface // arcs_link_if

/* File: design/arcs_device.sv */
// converter end: readout, offset calibration and standby control
//
// Behaviour
// - ready low, then msb first per rise
// - 24-bit two's complement, saturating at full scale
// - extra clock forces line high until ready
// - host must read before next result
// - host avoids reading during update interval
// - result every 12.5 or 100 ms
// - host gives two extra clocks for calibration
// - 25th clock drives line high
// - calibration starts at 26th falling edge
// - later clocks do not abort calibration
// - calibration isolates inputs, applies internal signal
// - calibration end pulls line low, result valid
// - first calibrated result 101.28 or 801.02 ms
// - standby powers analog down, clock stays
// - host raises clock to request standby
// - standby accepted mid readback
// - standby after clock high 12.46/99.96 ms
// - line high throughout standby
// - clock low ends standby, converting resumes
// - first ready 52.51 or 401.8 ms after wake
`timescale 1ns/1ps
module arcs_device #(
  parameter logic [24:0] P_CONV_FAST = 25'(arcs_pkg::CONV_FAST_CYC),
  parameter logic [24:0] P_CONV_SLOW = 25'(arcs_pkg::CONV_SLOW_CYC),
  parameter logic [24:0] P_CAL_FAST  = 25'(arcs_pkg::CAL_FAST_CYC),
  parameter logic [24:0] P_CAL_SLOW  = 25'(arcs_pkg::CAL_SLOW_CYC),
  parameter logic [24:0] P_STBY_FAST = 25'(arcs_pkg::STBY_FAST_CYC),
  parameter logic [24:0] P_STBY_SLOW = 25'(arcs_pkg::STBY_SLOW_CYC),
  parameter logic [24:0] P_WAKE_FAST = 25'(arcs_pkg::WAKE_FAST_CYC),
  parameter logic [24:0] P_WAKE_SLOW = 25'(arcs_pkg::WAKE_SLOW_CYC)
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // link to host
  arcs_link_if.dev                   link,
  // converter side
  input  wire logic                  rate_fast,
  input  wire logic signed [25:0]    sample_in,
  output logic                       analog_isolate,
  output logic                       analog_pd,
  output logic                       result_ready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] sat24(input logic signed [25:0] s);
    if (s > 26'sh07fffff) begin
      sat24 = 24'h7fffff;
    end else if (s < -26'sh0800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = s[23:0];
    end
  endfunction

  function automatic logic [24:0] period_of(input arcs_pkg::arcs_dev_state_type m,
                                            input logic fast);
    case (m)
      arcs_pkg::DEV_CAL:  period_of = fast ? P_CAL_FAST : P_CAL_SLOW;
      arcs_pkg::DEV_WAKE: period_of = fast ? P_WAKE_FAST : P_WAKE_SLOW;
      default:            period_of = fast ? P_CONV_FAST : P_CONV_SLOW;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                              sclk_meta_ff;
  logic                              sclk_sync_ff;
  logic                              sclk_sync2_ff;
  logic                              sclk_lvl_ff;
  logic                              sclk_rise;
  logic                              sclk_fall;
  arcs_pkg::arcs_dev_state_type      mode_ff;
  logic [24:0]                       tmr_ff;
  logic [24:0]                       hi_cnt_ff;
  logic [24:0]                       period;
  logic [24:0]                       stby_cyc;
  logic                              done;
  logic                              rdy;
  logic                              upd_win;
  logic                              enter_stby;
  logic                              enter_cal;
  logic [4:0]                        pcnt_ff;
  logic                              armed_ff;
  logic [23:0]                       shift_ff;
  logic                              line_ff;
  logic                              rdy_ff;

  // ----------------------------------------------------------------
  // serial clock sampling
  // ----------------------------------------------------------------
  // the filtered level only moves when the last two stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_meta_ff  <= 1'b0;
      sclk_sync_ff  <= 1'b0;
      sclk_sync2_ff <= 1'b0;
    end else begin
      sclk_meta_ff  <= link.sclk;
      sclk_sync_ff  <= sclk_meta_ff;
      sclk_sync2_ff <= sclk_sync_ff;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_lvl_ff <= 1'b0;
    end else if (sclk_sync_ff == sclk_sync2_ff) begin
      sclk_lvl_ff <= sclk_sync2_ff;
    end
  end

  assign sclk_rise = sclk_sync_ff & sclk_sync2_ff & ~sclk_lvl_ff;
  assign sclk_fall = ~sclk_sync_ff & ~sclk_sync2_ff & sclk_lvl_ff;

  // ----------------------------------------------------------------
  // timing decode
  // ----------------------------------------------------------------
  assign period     = period_of(mode_ff, rate_fast);
  assign stby_cyc   = rate_fast ? P_STBY_FAST : P_STBY_SLOW;
  // a rate change mid interval must not let the timer run past its end
  assign done       = (mode_ff != arcs_pkg::DEV_STBY) && (tmr_ff >= period - 25'h1);
  assign rdy        = done;
  assign upd_win    = (mode_ff != arcs_pkg::DEV_STBY) &&
                      (tmr_ff >= period - 25'(arcs_pkg::UPD_CYC));
  assign enter_stby = (mode_ff != arcs_pkg::DEV_STBY) && sclk_lvl_ff &&
                      (hi_cnt_ff >= stby_cyc);
  // later pulses are ignored once calibration runs
  assign enter_cal  = sclk_fall && (pcnt_ff == arcs_pkg::PCNT_CAL) &&
                      (mode_ff != arcs_pkg::DEV_CAL);

  // ----------------------------------------------------------------
  // high-time counter for standby request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_ff <= 25'h0;
    end else if (!sclk_lvl_ff) begin
      hi_cnt_ff <= 25'h0;
    end else if (hi_cnt_ff != 25'h1ffffff) begin
      hi_cnt_ff <= hi_cnt_ff + 25'h1;
    end
  end

  // ----------------------------------------------------------------
  // mode and interval timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= arcs_pkg::DEV_RUN;
      tmr_ff  <= 25'h0;
    end else if (enter_stby) begin
      mode_ff <= arcs_pkg::DEV_STBY;
      tmr_ff  <= 25'h0;
    end else begin
      case (mode_ff)
        arcs_pkg::DEV_STBY: begin
          if (!sclk_lvl_ff) begin
            mode_ff <= arcs_pkg::DEV_WAKE;
          end
          tmr_ff <= 25'h0;
        end
        default: begin
          if (enter_cal) begin
            mode_ff <= arcs_pkg::DEV_CAL;
            tmr_ff  <= 25'h0;
          end else if (done) begin
            mode_ff <= arcs_pkg::DEV_RUN;
            tmr_ff  <= 25'h0;
          end else begin
            tmr_ff <= tmr_ff + 25'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pulse counter since ready
  // ----------------------------------------------------------------
  // starts saturated so no pulse means anything before the first result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pcnt_ff <= arcs_pkg::PCNT_RESET;
    end else if (rdy) begin
      pcnt_ff <= 5'h0;
    end else if (sclk_rise && pcnt_ff != arcs_pkg::PCNT_SAT) begin
      pcnt_ff <= pcnt_ff + 5'h1;
    end
  end

  // ----------------------------------------------------------------
  // result shifter
  // ----------------------------------------------------------------
  // an unread result is simply replaced by the next one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_ff <= 24'h0;
      armed_ff <= 1'b0;
    end else if (rdy) begin
      shift_ff <= sat24(sample_in);
      armed_ff <= 1'b1;
    end else if (upd_win || enter_stby || enter_cal) begin
      armed_ff <= 1'b0;
    end else if (sclk_rise && armed_ff && pcnt_ff < arcs_pkg::PCNT_DATA) begin
      shift_ff <= {shift_ff[22:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // ready / data line
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_ff <= 1'b1;
    end else if (mode_ff == arcs_pkg::DEV_STBY || enter_stby) begin
      line_ff <= 1'b1;
    end else if (rdy) begin
      line_ff <= 1'b0;
    end else if (upd_win || enter_cal) begin
      line_ff <= 1'b1;
    end else if (sclk_rise && armed_ff) begin
      if (pcnt_ff < arcs_pkg::PCNT_DATA) begin
        line_ff <= shift_ff[23];
      end else if (pcnt_ff == arcs_pkg::PCNT_DATA) begin
        line_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_ff <= 1'b0;
    end else begin
      rdy_ff <= rdy;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.ready_data_out = line_ff;
  assign result_ready        = rdy_ff;
  // only the clock source keeps running in standby
  assign analog_pd           = (mode_ff == arcs_pkg::DEV_STBY);
  assign analog_isolate      = (mode_ff == arcs_pkg::DEV_CAL);

endmodule // arcs_device

/* File: design/arcs_host.sv */
// host end: makes the serial clock, reads results, requests modes
`timescale 1ns/1ps
module arcs_host (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // link to converter
  arcs_link_if.host         link,
  // control
  input  wire logic         read_en,
  input  wire logic [1:0]   extra_clks,
  input  wire logic         standby_req,
  output logic              busy,
  // results
  output logic [23:0]       result_data,
  output logic              result_valid,
  input  wire logic         result_ready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                          rdy_meta_ff;
  logic                          rdy_sync_ff;
  logic                          rdy_sync2_ff;
  logic                          rdy_lvl_ff;
  arcs_pkg::arcs_host_state_type st_ff;
  logic [2:0]                    half_ff;
  logic [4:0]                    pulses_ff;
  logic [4:0]                    total_ff;
  logic [23:0]                   word_ff;
  logic                          armed_ff;
  logic                          sclk_ff;
  logic                          push;
  logic                          pop;
  logic                          full;
  logic [23:0]                   buf_ff [2];
  logic                          wr_ff;
  logic                          rd_ff;
  logic [1:0]                    cnt_ff;

  // ----------------------------------------------------------------
  // ready line sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_meta_ff  <= 1'b1;
      rdy_sync_ff  <= 1'b1;
      rdy_sync2_ff <= 1'b1;
      rdy_lvl_ff   <= 1'b1;
    end else begin
      rdy_meta_ff  <= link.ready_data_out;
      rdy_sync_ff  <= rdy_meta_ff;
      rdy_sync2_ff <= rdy_sync_ff;
      if (rdy_sync_ff == rdy_sync2_ff) begin
        rdy_lvl_ff <= rdy_sync2_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // readout sequencer
  // ----------------------------------------------------------------
  // a read only starts with room in the buffer, so no buffered word is overwritten
  assign push = (st_ff == arcs_pkg::HOST_LOW) && (half_ff == arcs_pkg::HALF_LAST) &&
                (pulses_ff == total_ff) && !standby_req;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff     <= arcs_pkg::HOST_IDLE;
      half_ff   <= 3'h0;
      pulses_ff <= 5'h0;
      total_ff  <= arcs_pkg::PCNT_DATA;
      word_ff   <= 24'h0;
      armed_ff  <= 1'b0;
      sclk_ff   <= 1'b0;
    end else begin
      case (st_ff)
        arcs_pkg::HOST_IDLE: begin
          half_ff <= 3'h0;
          // a high line seen while idle arms a read, including a high last data bit left by a 24-clock read
          if (rdy_lvl_ff) begin
            armed_ff <= 1'b1;
          end
          if (standby_req) begin
            st_ff   <= arcs_pkg::HOST_STBY;
            sclk_ff <= 1'b1;
          end else if (read_en && !rdy_lvl_ff && armed_ff && !full) begin
            st_ff     <= arcs_pkg::HOST_HIGH;
            sclk_ff   <= 1'b1;
            armed_ff  <= 1'b0;
            pulses_ff <= 5'h1;
            total_ff  <= arcs_pkg::PCNT_DATA + 5'(extra_clks);
          end
        end
        arcs_pkg::HOST_HIGH: begin
          half_ff <= half_ff + 3'h1;
          // keep the clock high, so no short low pulse escapes
          if (standby_req) begin
            st_ff <= arcs_pkg::HOST_STBY;
          end else if (half_ff == arcs_pkg::HALF_LAST) begin
            st_ff   <= arcs_pkg::HOST_LOW;
            sclk_ff <= 1'b0;
          end
        end
        arcs_pkg::HOST_LOW: begin
          half_ff <= half_ff + 3'h1;
          // wait for the end of the low phase to keep the pulse width
          if (standby_req && half_ff == arcs_pkg::HALF_LAST) begin
            st_ff   <= arcs_pkg::HOST_STBY;
            sclk_ff <= 1'b1;
          end else if (half_ff == arcs_pkg::HALF_LAST) begin
            if (pulses_ff <= arcs_pkg::PCNT_DATA) begin
              word_ff <= {word_ff[22:0], rdy_lvl_ff};
            end
            if (pulses_ff == total_ff) begin
              st_ff <= arcs_pkg::HOST_IDLE;
            end else begin
              st_ff     <= arcs_pkg::HOST_HIGH;
              sclk_ff   <= 1'b1;
              pulses_ff <= pulses_ff + 5'h1;
            end
          end
        end
        default: begin
          if (!standby_req) begin
            st_ff   <= arcs_pkg::HOST_IDLE;
            sclk_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // two-entry result buffer
  // ----------------------------------------------------------------
  assign full = (cnt_ff == 2'h2);
  assign pop  = result_valid && result_ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      cnt_ff    <= 2'h0;
      buf_ff[0] <= 24'h0;
      buf_ff[1] <= 24'h0;
    end else begin
      if (push) begin
        // pulses past the last data bit shift nothing into the word
        if (total_ff == arcs_pkg::PCNT_DATA) begin
          buf_ff[wr_ff] <= {word_ff[22:0], rdy_lvl_ff};
        end else begin
          buf_ff[wr_ff] <= word_ff;
        end
        wr_ff         <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.sclk    = sclk_ff;
  assign result_data  = buf_ff[rd_ff];
  assign result_valid = (cnt_ff != 2'h0);
  assign busy         = (st_ff != arcs_pkg::HOST_IDLE);

endmodule // arcs_host

/* File: tb/arcs_link_asserts.sv */
// checker for the converter link wire and mode outputs
`timescale 1ns/1ps
module arcs_link_asserts #(
  parameter int STBY = 3000,
  parameter int CAL  = 8000
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link wire
  input wire logic sclk,
  input wire logic ready_data_out,
  // mode outputs
  input wire logic analog_isolate,
  input wire logic analog_pd
);
  logic [15:0] hi_cnt_ff;
  logic [15:0] iso_cnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // helper counters, saturating so long holds cannot wrap
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_cnt_ff <= 16'h0000;
    else if (!sclk) hi_cnt_ff <= 16'h0000;
    else if (hi_cnt_ff != 16'hffff) hi_cnt_ff <= hi_cnt_ff + 16'h0001;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) iso_cnt_ff <= 16'h0000;
    else if (!analog_isolate) iso_cnt_ff <= 16'h0000;
    else if (iso_cnt_ff != 16'hffff) iso_cnt_ff <= iso_cnt_ff + 16'h0001;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_stby_line_high: assert property (analog_pd |-> ready_data_out)
    else $error("line low in standby");
  a_modes_excl: assert property (!(analog_isolate && analog_pd))
    else $error("standby and calibration together");
  a_cal_on_fall: assert property ($rose(analog_isolate) |-> !sclk && $past(sclk, 8))
    else $error("calibration not started by a falling clock");
  a_cal_line_high: assert property (analog_isolate ##1 analog_isolate |-> $past(ready_data_out))
    else $error("line low during calibration");
  a_cal_end_ready: assert property ($fell(analog_isolate) |-> ##[0:3] !ready_data_out)
    else $error("no ready after calibration");
  a_cal_length: assert property ($fell(analog_isolate) |-> iso_cnt_ff inside {[CAL-4:CAL+4]})
    else $error("calibration length off");
  a_stby_entry: assert property ($rose(analog_pd) |-> hi_cnt_ff inside {[STBY-1:STBY+8]})
    else $error("standby entered at wrong time");
  a_wake_on_low: assert property (analog_pd && !sclk |-> ##[1:6] !analog_pd)
    else $error("standby not left on low clock");
endmodule // arcs_link_asserts

/* File: tb/adc_readout_cal_standby_tb.sv */
// self-checking bench joining converter and host ends
`timescale 1ns/1ps
module adc_readout_cal_standby_tb;
  localparam int CONV_F = 4000;
  localparam int CONV_S = 6000;
  localparam int CAL    = 8000;
  localparam int STBY   = 3000;
  localparam int WAKE   = 6000;
  localparam logic signed [25:0] TBL [6] = '{26'sh07fffff, 26'sh0800000, -26'sh0800000,
                                           -26'sh0800001, 26'sh0000000, -26'sh0000001};
  logic               clk          = 1'b0;
  logic               resetn       = 1'b0;
  logic               rate_fast    = 1'b1;
  logic signed [25:0] sample_in    = 26'sh07fffff;
  logic               read_en      = 1'b1;
  logic [1:0]         extra_clks   = 2'h0;
  logic               standby_req  = 1'b0;
  logic               cons_rdy     = 1'b1;
  logic               analog_isolate;
  logic               analog_pd;
  logic               dev_rdy;
  logic               busy;
  logic [23:0]        result_data;
  logic               result_valid;
  logic [23:0]        exp_q[$];
  logic [23:0]        last_e;
  logic [31:0]        lf           = 32'h5768;
  int                 n_errors     = 0;
  int                 n_checks     = 0;
  int                 k            = 1;
  int                 n;
  int                 cyc          = 0;
  int                 last_cyc     = 0;
  int                 gap          = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  arcs_link_if link_bus ();
  arcs_device #(.P_CONV_FAST(25'(CONV_F)), .P_CONV_SLOW(25'(CONV_S)), .P_CAL_FAST(25'(CAL)),
    .P_CAL_SLOW(25'(CAL)), .P_STBY_FAST(25'(STBY)), .P_STBY_SLOW(25'(STBY)),
    .P_WAKE_FAST(25'(WAKE)), .P_WAKE_SLOW(25'(WAKE))) i_arcs_device (
    .clk(clk), .resetn(resetn), .link(link_bus), .rate_fast(rate_fast),
    .sample_in(sample_in), .analog_isolate(analog_isolate), .analog_pd(analog_pd),
    .result_ready(dev_rdy));
  arcs_host i_arcs_host (.clk(clk), .resetn(resetn), .link(link_bus), .read_en(read_en),
    .extra_clks(extra_clks), .standby_req(standby_req), .busy(busy),
    .result_data(result_data), .result_valid(result_valid), .result_ready(cons_rdy));
  arcs_link_asserts #(.STBY(STBY), .CAL(CAL)) i_arcs_link_asserts (.clk(clk),
    .resetn(resetn), .sclk(link_bus.sclk), .ready_data_out(link_bus.ready_data_out),
    .analog_isolate(analog_isolate), .analog_pd(analog_pd));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [23:0] sat(input logic signed [25:0] v);
    if (v > 26'sh07fffff) return 24'h7fffff;
    if (v < -26'sh0800000) return 24'h800000;
    return v[23:0];
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int s);
    n_checks++;
    if (s < lo || s > hi) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  // wait one ready, note its word, then load the sample for the next one
  task automatic nxt(input bit keep, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (dev_rdy !== 1'b1 && n < lim);
    #2;
    rng("ready wait", 1, lim - 1, n);
    gap = cyc - last_cyc;
    last_cyc = cyc;
    last_e = sat(sample_in);
    if (keep) exp_q.push_back(last_e);
    lf = lfsr(lf);
    sample_in = (k < 6) ? TBL[k] : lf[25:0];
    k++;
  endtask
  task automatic wait_lvl(input logic v);
    int t;
    t = 0;
    while (link_bus.sclk !== v && t < 300) begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic wire_chk(input int nb);
    for (int j = 0; j < nb; j++) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      tick(6);
      chk("line bit", {23'h0, (j < 24) ? last_e[23-j] : 1'b1},
          {23'h0, link_bus.ready_data_out});
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scoreboard and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (result_valid === 1'b1 && cons_rdy === 1'b1)
      chk("word", (exp_q.size() > 0) ? exp_q.pop_front() : ~result_data, result_data);
  end
  initial begin
    #2400000;
    n_errors++;
    $display("watchdog expired");
    test_done();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(3);
    resetn = 1'b1;
    nxt(1, CONV_F + 100);
    for (int i = 0; i < 5; i++) begin
      nxt(1, CONV_F + 100);
      rng("fast period", CONV_F, CONV_F, gap);
      wire_chk(24 + int'(extra_clks));
      extra_clks = 2'((i + 1) % 2);
    end
    $display("test readout done");
    rate_fast = 1'b0;
    nxt(1, CONV_S + 100);
    nxt(1, CONV_S + 100);
    rng("slow period", CONV_S, CONV_S, gap);
    rate_fast = 1'b1;
    nxt(1, CONV_S + 100);
    $display("test rate done");
    tick(600);
    cons_rdy = 1'b0;
    nxt(1, CONV_F + 100);
    nxt(1, CONV_F + 100);
    tick(600);
    chk("held valid", 24'h1, {23'h0, result_valid});
    nxt(0, CONV_F + 100);
    // free the consumer inside the update window so the lost word is not read late
    tick(2600);
    cons_rdy = 1'b1;
    nxt(1, CONV_F + 100);
    $display("test buffer done");
    tick(600);
    extra_clks = 2'h2;
    nxt(1, CONV_F + 100);
    n = 0;
    while (analog_isolate !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    chk("isolate", 24'h1, {23'h0, analog_isolate});
    extra_clks = 2'h0;
    nxt(1, CAL + 1000);
    rng("cal time", CAL - 8, CAL + 8, n);
    chk("isolate end", 24'h0, {23'h0, analog_isolate});
    $display("test calibration done");
    nxt(0, CONV_F + 100);
    tick(100);
    standby_req = 1'b1;
    n = 0;
    while (analog_pd !== 1'b1 && n < STBY + 500) begin
      tick(1);
      n++;
    end
    rng("stby time", STBY - 8, STBY + 16, n);
    chk("stby line", 24'h1, {23'h0, link_bus.ready_data_out});
    tick(1000);
    chk("stby held", 24'h1, {23'h0, analog_pd});
    chk("busy stby", 24'h1, {23'h0, busy});
    standby_req = 1'b0;
    nxt(1, WAKE + 500);
    rng("wake time", WAKE, WAKE + 16, n);
    chk("awake", 24'h0, {23'h0, analog_pd});
    tick(600);
    chk("words left", 24'h0, 24'(exp_q.size()));
    chk("busy idle", 24'h0, {23'h0, busy});
    $display("test standby done");
    test_done();
  end
endmodule // adc_readout_cal_standby_tb
